// File: core/rgp_gpio_pairs.sv
/*
  Register-controlled pin pairs: two configuration registers, each
  holding the mode and output value of two general-purpose pins, a
  read-only register of synchronised pin levels, and the APB slave
  that reaches them.
  Assumes an APB master on clk, a synchronous active-high reset, and
  board pads that combine pin_out and pin_oe_n into the pin's level.
*/
`timescale 1ns/1ps
`include "rgp_params.svh"

// Notes on behaviour
// RULE_01: Mode 00 functional input, 10 tri-stated.
// RULE_02: Mode 01 drives the output-value bit.
// RULE_03: Mode 11 is undriven GPIO input.
// RULE_04: Pin driven only in GPIO output mode.
// RULE_05: Value 0 low, 1 high; reset zeros.
// RULE_06: Upper pin 7,5:4; lower pin 3,1:0.
// RULE_07: Reserved bits 6, 2 read zero.
module rgp_gpio_pairs #(
  parameter int ADDR_W = 8
) (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [ADDR_W-1:0]      paddr,
  input  wire rgp_pkg::rgp_word_t     pwdata,
  input  wire logic [3:0]             pstrb,
  output rgp_pkg::rgp_word_t          prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic [`RGP_PIN_COUNT-1:0] pin_in,
  output logic [`RGP_PIN_COUNT-1:0]   pin_out,
  output logic [`RGP_PIN_COUNT-1:0]   pin_oe_n,
  output logic [`RGP_PIN_COUNT-1:0]   func_in
);
  import rgp_pkg::*;

  localparam int PINS = `RGP_PIN_COUNT;

  rgp_byte_t        pair_lo_reg;
  rgp_byte_t        pair_lo_next;
  rgp_byte_t        pair_hi_reg;
  rgp_byte_t        pair_hi_next;
  rgp_word_t        prdata_reg;
  rgp_word_t        prdata_next;
  logic             pslverr_reg;
  logic             pslverr_next;
  rgp_mode_t        mode [PINS];
  logic [PINS-1:0]  out_val;
  logic [PINS-1:0]  gpio_in;
  logic             setup_phase;
  logic             access_wr;
  logic             hit_lo;
  logic             hit_hi;
  logic             hit_level;
  logic             hit_any;

  // Compares the bus address with the byte address of an index.
  function automatic logic addr_hit(input logic [ADDR_W-1:0] addr,
                                    input rgp_byte_t         idx);
    addr_hit = (addr == ADDR_W'(rgp_byte_addr(idx)));
  endfunction : addr_hit

  // Keeps only writable bits, so reserved bits always store zero.
  function automatic rgp_byte_t cfg_write(input rgp_byte_t wdata);
    cfg_write = wdata & `RGP_CFG_WR_MASK; // RULE_07
  endfunction : cfg_write

  // Mode field of the upper or lower pin of one register.
  function automatic rgp_mode_t pin_mode(input rgp_byte_t r,
                                         input logic      upper);
    if (upper) begin
      pin_mode = rgp_mode_t'(r[`RGP_HI_MODE_MSB:`RGP_HI_MODE_LSB]);
    end else begin
      pin_mode = rgp_mode_t'(r[`RGP_LO_MODE_MSB:`RGP_LO_MODE_LSB]);
    end
  endfunction : pin_mode

  // Output-value bit of the upper or lower pin of one register.
  function automatic logic pin_val(input rgp_byte_t r,
                                   input logic      upper);
    pin_val = upper ? r[`RGP_HI_VAL_BIT] : r[`RGP_LO_VAL_BIT];
  endfunction : pin_val

  // Bus phases and address decode. The slave never stalls, so every
  // access phase completes at its first edge.
  assign pready      = 1'b1;
  assign setup_phase = psel && !penable;
  assign access_wr   = psel && penable && pwrite && pready;
  assign hit_lo      = addr_hit(paddr, `RGP_IDX_PAIR_LO);
  assign hit_hi      = addr_hit(paddr, `RGP_IDX_PAIR_HI);
  assign hit_level   = addr_hit(paddr, `RGP_IDX_LEVEL);
  assign hit_any     = hit_lo || hit_hi || hit_level;

  // Next value of the lower configuration register. Only byte lane 0
  // carries the register, so other lanes are ignored.
  always_comb begin
    pair_lo_next = pair_lo_reg;
    if (access_wr && hit_lo && pstrb[0]) begin
      pair_lo_next = cfg_write(pwdata[7:0]); // RULE_06
    end
  end

  // Next value of the upper configuration register.
  always_comb begin
    pair_hi_next = pair_hi_reg;
    if (access_wr && hit_hi && pstrb[0]) begin
      pair_hi_next = cfg_write(pwdata[7:0]); // RULE_06
    end
  end

  // Lower configuration register: pins a (low half) and b (high half).
  always_ff @(posedge clk) begin
    if (rst) begin
      pair_lo_reg <= `RGP_CFG_RESET; // RULE_05
    end else begin
      pair_lo_reg <= pair_lo_next;
    end
  end

  // Upper configuration register: pins c (low half) and d (high half).
  always_ff @(posedge clk) begin
    if (rst) begin
      pair_hi_reg <= `RGP_CFG_RESET; // RULE_05
    end else begin
      pair_hi_reg <= pair_hi_next;
    end
  end

  // Field split to the four pins; pin index 0..3 is a, b, c, d.
  assign mode[0]    = pin_mode(pair_lo_reg, 1'b0); // RULE_06
  assign mode[1]    = pin_mode(pair_lo_reg, 1'b1); // RULE_06
  assign mode[2]    = pin_mode(pair_hi_reg, 1'b0);
  assign mode[3]    = pin_mode(pair_hi_reg, 1'b1);
  assign out_val[0] = pin_val(pair_lo_reg, 1'b0);
  assign out_val[1] = pin_val(pair_lo_reg, 1'b1);
  assign out_val[2] = pin_val(pair_hi_reg, 1'b0);
  assign out_val[3] = pin_val(pair_hi_reg, 1'b1);

  // Read data and error are prepared in the setup cycle, so both come
  // from flip-flops yet are valid for the zero-wait access phase.
  always_comb begin
    prdata_next  = prdata_reg;
    pslverr_next = pslverr_reg;
    if (setup_phase) begin
      pslverr_next = !hit_any;
      prdata_next  = `RGP_WORD_ZERO;
      if (!pwrite && hit_lo) begin
        prdata_next = rgp_word_t'(pair_lo_reg); // RULE_07
      end else if (!pwrite && hit_hi) begin
        prdata_next = rgp_word_t'(pair_hi_reg); // RULE_07
      end else if (!pwrite && hit_level) begin
        prdata_next = rgp_word_t'(gpio_in);
      end
    end
  end

  // Bus answer registers.
  always_ff @(posedge clk) begin
    if (rst) begin
      prdata_reg  <= `RGP_WORD_ZERO;
      pslverr_reg <= 1'b0;
    end else begin
      prdata_reg  <= prdata_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign prdata  = prdata_reg;
  assign pslverr = pslverr_reg;

  // One pin cell per pin, each with its own synchroniser and driver.
  for (genvar g = 0; g < PINS; g++) begin : g_pin
    rgp_pin_cell u_cell (
      .clk      (clk),
      .rst      (rst),
      .mode     (mode[g]),
      .out_val  (out_val[g]),
      .pin_in   (pin_in[g]),
      .pin_out  (pin_out[g]),
      .pin_oe_n (pin_oe_n[g]),
      .func_in  (func_in[g]),
      .gpio_in  (gpio_in[g])
    );

    // Functional input and tri-state leave the pin undriven next cycle.
    AST_FUNC_TRI_UNDRIVEN: assert property ( // RULE_01
      @(posedge clk) disable iff (rst)
      (mode[g] == RGP_FUNC_IN || mode[g] == RGP_TRISTATE)
        |=> (pin_oe_n[g] && !pin_out[g]))
      else $error("pin driven in functional input or tri-state mode");

    // Output mode drives exactly the stored value one cycle later.
    AST_OUT_DRIVES_VALUE: assert property ( // RULE_02
      @(posedge clk) disable iff (rst)
      (mode[g] == RGP_GPIO_OUT)
        |=> (!pin_oe_n[g] && pin_out[g] == $past(out_val[g])))
      else $error("output mode does not drive the stored value");

    // GPIO input mode never drives and keeps the level readable.
    AST_IN_UNDRIVEN: assert property ( // RULE_03
      @(posedge clk) disable iff (rst)
      (mode[g] == RGP_GPIO_IN) [*2] |-> pin_oe_n[g])
      else $error("pin driven in GPIO input mode");

    // Any cycle with the driver on traces back to output mode.
    AST_DRIVE_ONLY_OUT: assert property ( // RULE_04
      @(posedge clk) disable iff (rst)
      !pin_oe_n[g] |-> ($past(mode[g]) == RGP_GPIO_OUT))
      else $error("pin driven outside GPIO output mode");

    // The core sees a functional input only in functional input mode.
    AST_FUNC_GATED: assert property ( // RULE_01
      @(posedge clk) disable iff (rst)
      (mode[g] != RGP_FUNC_IN) [*2] |=> !func_in[g])
      else $error("functional input passed in another mode");
  end

  // Leaving reset, both registers are zero and no pin is driven.
  AST_RESET_ZERO: assert property ( // RULE_05
    @(posedge clk)
    $fell(rst) |-> (pair_lo_reg == `RGP_CFG_RESET
                    && pair_hi_reg == `RGP_CFG_RESET
                    && &pin_oe_n && !(|pin_out)))
    else $error("registers or pins not at reset state");

  // A write to the lower register lands in its fields next cycle.
  AST_FIELD_MAP_LO: assert property ( // RULE_06
    @(posedge clk) disable iff (rst)
    (access_wr && hit_lo && pstrb[0])
      |=> (pair_lo_reg == cfg_write($past(pwdata[7:0]))
           && mode[1] == rgp_mode_t'($past(pwdata[5:4]))
           && out_val[0] == $past(pwdata[3])))
    else $error("lower register fields misplaced after write");

  // A write to the upper register lands in its fields next cycle.
  AST_FIELD_MAP_HI: assert property ( // RULE_06
    @(posedge clk) disable iff (rst)
    (access_wr && hit_hi && pstrb[0])
      |=> (pair_hi_reg == cfg_write($past(pwdata[7:0]))
           && out_val[3] == $past(pwdata[7])))
    else $error("upper register fields misplaced after write");

  // Reserved bits are never stored and never read back as one.
  AST_RESERVED_ZERO: assert property ( // RULE_07
    @(posedge clk) disable iff (rst)
    (psel && penable && !pwrite && (hit_lo || hit_hi))
      |-> (!prdata[`RGP_RSV_HI_BIT] && !prdata[`RGP_RSV_LO_BIT]
           && !pair_lo_reg[`RGP_RSV_HI_BIT]
           && !pair_lo_reg[`RGP_RSV_LO_BIT]
           && !pair_hi_reg[`RGP_RSV_HI_BIT]
           && !pair_hi_reg[`RGP_RSV_LO_BIT]))
    else $error("reserved bit reads as one");

  // An unmapped address answers with an error and zero data.
  AST_UNMAPPED_ERR: assert property (
    @(posedge clk) disable iff (rst)
    (setup_phase && !hit_any) |=> (pslverr && prdata == `RGP_WORD_ZERO))
    else $error("unmapped access not answered with an error");

endmodule : rgp_gpio_pairs

// File: pkg/rgp_params.svh
/*
  Constants of the register-controlled pin pairs: register indices,
  field positions, reset values and masks.
  Assumes it is included by its bare name wherever a value is needed.
*/
`ifndef RGP_PARAMS_SVH
`define RGP_PARAMS_SVH

// Register indices; the APB byte address is four times the index.
`define RGP_IDX_PAIR_LO   8'h10
`define RGP_IDX_PAIR_HI   8'h11
`define RGP_IDX_LEVEL     8'h20

// Number of pins handled, two per configuration register.
`define RGP_PIN_COUNT     4

// Field positions inside one configuration register.
`define RGP_HI_VAL_BIT    7
`define RGP_HI_MODE_MSB   5
`define RGP_HI_MODE_LSB   4
`define RGP_LO_VAL_BIT    3
`define RGP_LO_MODE_MSB   1
`define RGP_LO_MODE_LSB   0
`define RGP_RSV_HI_BIT    6
`define RGP_RSV_LO_BIT    2

// Reset value and writable-bit mask of a configuration register.
`define RGP_CFG_RESET     8'h00
`define RGP_CFG_WR_MASK   8'hbb

// Reset values of the bus answer, of the pin drivers and of the input levels.
`define RGP_WORD_ZERO     32'h0000_0000
`define RGP_PIN_IDLE_OE_N 1'b1
`define RGP_PIN_IDLE_OUT  1'b0
`define RGP_LVL_RESET     1'b0

`endif

// File: pkg/rgp_pkg.sv
/*
  Types and shared helpers of the register-controlled pin pairs.
  Assumes rgp_params.svh is on the include path.
*/
`include "rgp_params.svh"

package rgp_pkg;

  // Pin modes in field-code order: 00, 01, 10, 11.
  typedef enum logic [1:0] {
    RGP_FUNC_IN,
    RGP_GPIO_OUT,
    RGP_TRISTATE,
    RGP_GPIO_IN
  } rgp_mode_t;

  typedef logic [7:0]  rgp_byte_t;
  typedef logic [31:0] rgp_word_t;
  typedef logic [9:0]  rgp_baddr_t;

  // Byte address of a register from its index.
  function automatic rgp_baddr_t rgp_byte_addr(input rgp_byte_t idx);
    rgp_byte_addr = {idx, 2'b00};
  endfunction : rgp_byte_addr

endpackage : rgp_pkg

// File: core/rgp_pin_cell.sv
/*
  One general-purpose pin: input synchroniser and registered driver.
  Assumes mode and out_val come from registers on clk, and that the
  pad outside resolves the wire from pin_out and pin_oe_n.
*/
`timescale 1ns/1ps
`include "rgp_params.svh"

module rgp_pin_cell (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire rgp_pkg::rgp_mode_t mode,
  input  wire logic               out_val,
  input  wire logic               pin_in,
  output logic                    pin_out,
  output logic                    pin_oe_n,
  output logic                    func_in,
  output logic                    gpio_in
);
  import rgp_pkg::*;

  logic sync1_reg;
  logic sync2_reg;
  logic func_reg;
  logic out_reg;
  logic oe_n_reg;

  // Two-stage synchroniser; the first stage feeds the second only.
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_reg <= `RGP_LVL_RESET;
      sync2_reg <= `RGP_LVL_RESET;
    end else begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
    end
  end

  // The core sees the pin only in functional input mode, else low.
  always_ff @(posedge clk) begin
    if (rst) begin
      func_reg <= `RGP_LVL_RESET;
    end else begin
      func_reg <= (mode == RGP_FUNC_IN) ? sync2_reg : `RGP_LVL_RESET; // RULE_01
    end
  end

  // Driver registered so the pad never sees a decode glitch.
  always_ff @(posedge clk) begin
    if (rst) begin
      oe_n_reg <= `RGP_PIN_IDLE_OE_N; // RULE_05
      out_reg  <= `RGP_PIN_IDLE_OUT;
    end else begin
      unique case (mode)
        RGP_FUNC_IN, RGP_TRISTATE: begin
          oe_n_reg <= `RGP_PIN_IDLE_OE_N; // RULE_01
          out_reg  <= `RGP_PIN_IDLE_OUT;
        end
        RGP_GPIO_OUT: begin
          oe_n_reg <= ~`RGP_PIN_IDLE_OE_N; // RULE_02 RULE_04
          out_reg  <= out_val; // RULE_05
        end
        RGP_GPIO_IN: begin
          oe_n_reg <= `RGP_PIN_IDLE_OE_N; // RULE_03
          out_reg  <= `RGP_PIN_IDLE_OUT;
        end
      endcase
    end
  end

  assign pin_out  = out_reg;
  assign pin_oe_n = oe_n_reg;
  assign func_in  = func_reg;
  assign gpio_in  = sync2_reg;

endmodule : rgp_pin_cell

// File: tb/rgp_board_model.sv
/*
  Board-side model of the four general-purpose pins.
  Assumes the bench changes ext_en and ext_val just after a clock edge.
*/
`timescale 1ns/1ps
module rgp_board_model (
  input  wire logic       clk,
  input  wire logic [3:0] pin_out,
  input  wire logic [3:0] pin_oe_n,
  input  wire logic [3:0] ext_en,
  input  wire logic [3:0] ext_val,
  output logic      [3:0] pin_in
);
  logic [3:0] float_reg = 4'h5;

  // A released wire with no pull wanders, so it flips every cycle.
  always @(posedge clk) begin
    float_reg <= ~pin_in;
  end

  // The device wins only where its enable is low; else board or drift.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (!pin_oe_n[i]) begin
        pin_in[i] = pin_out[i];
      end else if (ext_en[i]) begin
        pin_in[i] = ext_val[i];
      end else begin
        pin_in[i] = float_reg[i];
      end
    end
  end
endmodule : rgp_board_model

// File: tb/test_register_controlled_gpio_pairs.sv
/*
  Self-checking bench of the register-controlled pin pairs.
  Assumes the board model on the pins and a zero-wait APB slave.
*/
`timescale 1ns/1ps
`include "rgp_params.svh"
module test_register_controlled_gpio_pairs;
  import rgp_pkg::*;
  logic       clk, rst, psel, penable, pwrite;
  logic [7:0] paddr;
  rgp_word_t  pwdata, prdata;
  logic [3:0] pstrb, pin_in, pin_out, pin_oe_n, func_in, ext_en, ext_val;
  logic       pready, pslverr;
  int         fails, compares;
  logic [3:0] wstrb;
  localparam logic [9:0] A_LO  = {`RGP_IDX_PAIR_LO, 2'b00};
  localparam logic [9:0] A_HI  = {`RGP_IDX_PAIR_HI, 2'b00};
  localparam logic [9:0] A_LVL = {`RGP_IDX_LEVEL, 2'b00};

  rgp_gpio_pairs #(.ADDR_W(8)) dut_u (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .func_in(func_in));

  rgp_board_model board_u (.clk(clk), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .ext_en(ext_en), .ext_val(ext_val),
    .pin_in(pin_in));

  // Prints the verdict and stops the run.
  task complete_run;
    if (fails == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run

  task check(input string what, input rgp_word_t seen, input rgp_word_t exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // One APB transfer; entered and left just after a rising edge.
  task apb(input logic wr, input logic [9:0] a, input rgp_word_t d,
           output rgp_word_t rd, output logic err);
    int i;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a[7:0];
    pwdata <= d;
    pstrb <= wr ? wstrb : 4'h0;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin
      fails++;
      complete_run();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task wr(input logic [9:0] a, input rgp_word_t d);
    rgp_word_t r;
    logic      e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task rd_chk(input string n, input logic [9:0] a, input rgp_word_t exp);
    rgp_word_t r;
    logic      e;
    apb(1'b0, a, 32'h0, r, e);
    check(n, r, exp);
  endtask : rd_chk

  // Everything idle and both configuration words clear after reset.
  task t_reset;
    check("oe_n", pin_oe_n, 32'hf);
    check("pin_out", pin_out, 32'h0);
    rd_chk("cfg_lo", A_LO, 32'h0);
    rd_chk("cfg_hi", A_HI, 32'h0);
  endtask : t_reset

  // Each pin in turn as an output, both levels; the board pulls the
  // other pins high, so their functional inputs must pass a one.
  task t_output;
    logic [9:0] a;
    logic [3:0] m, en_n;
    rgp_word_t  d;
    ext_en <= 4'hf;
    ext_val <= 4'hf;
    for (int p = 0; p < 4; p++) begin
      for (int v = 0; v < 2; v++) begin
        a = (p < 2) ? A_LO : A_HI;
        d = p[0] ? (32'h10 | (v << 7)) : (32'h01 | (v << 3));
        m = 4'h1 << p;
        en_n = ~m;
        wr(a, d);
        repeat (4) @(posedge clk);
        check("oe_n", pin_oe_n, en_n);
        check("pin_out", pin_out, v ? m : 4'h0);
        check("func_in", func_in, en_n);
        rd_chk("cfg", a, d);
        wr(a, 32'h0);
      end
    end
  endtask : t_output

  // Functional input, tri-state and GPIO input; stored values set.
  task t_inputs;
    ext_en <= 4'hf;
    ext_val <= 4'h5;
    wr(A_LO, 32'ha8);
    wr(A_HI, 32'hbb);
    repeat (6) @(posedge clk);
    check("oe_n", pin_oe_n, 32'hf);
    check("pin_out", pin_out, 32'h0);
    check("func_in", func_in, 32'h1);
    rd_chk("level", A_LVL, 32'h5);
    ext_val <= 4'ha;
    repeat (6) @(posedge clk);
    check("func_in", func_in, 32'h0);
    rd_chk("level", A_LVL, 32'ha);
    wr(A_LO, 32'h0);
    wr(A_HI, 32'h0);
    ext_en <= 4'h0;
  endtask : t_inputs

  // Reserved bits stay clear, a write without lane 0 is dropped, and
  // an unmapped read is refused.
  task t_reserved;
    rgp_word_t r;
    logic      e;
    wr(A_HI, 32'hff);
    rd_chk("cfg_hi", A_HI, 32'hbb);
    wstrb = 4'he;
    wr(A_HI, 32'h0);
    rd_chk("cfg_hi_nostrb", A_HI, 32'hbb);
    wstrb = 4'hf;
    wr(A_HI, 32'h0);
    apb(1'b0, 10'h48, 32'h0, r, e);
    check("err", e, 32'h1);
    check("unmapped", r, 32'h0);
  endtask : t_reserved

  // Free-running 50 MHz clock.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Reset, then the scenarios in order.
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'h0;
    wstrb = 4'hf;
    ext_en = 4'h0;
    ext_val = 4'h0;
    fails = 0;
    compares = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_output();
    t_inputs();
    t_reserved();
    complete_run();
  end
endmodule : test_register_controlled_gpio_pairs
